// ==== src/bso_defines.svh ====
`ifndef BSO_DEFINES_SVH
`define BSO_DEFINES_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BSO_ADR_THRESHOLD   8'h14
`define BSO_ADR_REF_LOW     8'h15
`define BSO_ADR_REF_HIGH    8'h16
`define BSO_ADR_OFS_LOW     8'h18
`define BSO_ADR_OFS_HIGH    8'h19
`define BSO_ADR_INT_ORIGIN  8'h24
`define BSO_ADR_FILL_LEVEL  8'h25
`define BSO_ADR_QUEUE_FLAGS 8'h26
`define BSO_ADR_STATUS      8'h27
`define BSO_ADR_PRESS_LOW   8'h28
`define BSO_ADR_PRESS_MID   8'h29
`define BSO_ADR_PRESS_HIGH  8'h2A
`define BSO_ADR_TEMP_LOW    8'h2B
`define BSO_ADR_TEMP_HIGH   8'h2C
`define BSO_ADR_QUEUE_PLOW  8'h78
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BSO_BIT_BOOT_RUN    7
`define BSO_BIT_ANY_EVENT   2
`define BSO_BIT_DIFF_LOW    1
`define BSO_BIT_DIFF_HIGH   0
`define BSO_BIT_THR_REACHED 7
`define BSO_BIT_OVERWRITE   6
`define BSO_BIT_COMPLETE    5
`define BSO_BIT_TEMP_OVR    5
`define BSO_BIT_PRESS_OVR   4
`define BSO_BIT_TEMP_READY  1
`define BSO_BIT_PRESS_READY 0
// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define BSO_RST_BYTE        8'h00
`define BSO_RST_THRESHOLD   7'h00
`define BSO_RST_WORD        16'h0000
`define BSO_QUEUE_DEPTH     128
`define BSO_QUEUE_FULL      8'h80
`endif

// ==== src/bso_pkg.sv ====
`default_nettype none
package bso_pkg;
  typedef struct packed {
    logic        press_valid;
    logic [23:0] press_raw;
    logic        temp_valid;
    logic [15:0] temp_raw;
  } bso_sample_t;

  typedef struct packed {
    logic zero_capture;
    logic ref_auto_update;
    logic diff_interrupt_enable;
    logic halt_at_threshold;
    logic stream_mode;
  } bso_ctrl_t;

  typedef struct packed {
    logic boot_run;
    logic diff_low_event;
    logic diff_high_event;
  } bso_event_t;

  typedef enum logic [1:0] {
    BSO_Q_IDLE,
    BSO_Q_FILL,
    BSO_Q_HALT
  } bso_qstate_t;
endpackage
`default_nettype wire

// ==== src/bso_sample_queue.sv ====
`include "bso_defines.svh"
`default_nettype none
module bso_sample_queue
  import bso_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        push,
  input  wire logic [23:0] push_data,
  input  wire logic        pop,
  input  wire logic        halt_at_threshold,
  input  wire logic        stream_mode,
  input  wire logic [6:0]  threshold_level,
  output logic [7:0]       fill_count,
  output logic [23:0]      head_data,
  output logic             overwrite_seen
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [23:0] mem_ff [0:`BSO_QUEUE_DEPTH-1];
  logic [6:0]  wr_ptr_ff;
  logic [6:0]  rd_ptr_ff;
  logic [7:0]  cnt_ff;
  logic        ovr_ff;
  logic [7:0]  limit;
  logic        is_full;
  logic        do_pop;
  logic        do_push;
  logic        do_over;

  // halt mode shrinks the capacity to the threshold
  assign limit   = halt_at_threshold ? {1'b0, threshold_level} : `BSO_QUEUE_FULL;
  assign is_full = (cnt_ff >= limit);
  assign do_pop  = pop && (cnt_ff != 8'h00);
  assign do_push = push && !is_full;
  // stream mode drops the oldest; halt never overwrites
  assign do_over = push && is_full && stream_mode && !halt_at_threshold && (cnt_ff != 8'h00);

  always_ff @(posedge sys_clk) begin
    if (do_push || do_over) begin
      mem_ff[wr_ptr_ff] <= push_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_ff <= 7'h00;
      rd_ptr_ff <= 7'h00;
      cnt_ff    <= 8'h00;
      ovr_ff    <= 1'b0;
    end else begin
      if (do_push || do_over) begin
        wr_ptr_ff <= wr_ptr_ff + 7'h01;
      end
      if (do_pop || do_over) begin
        rd_ptr_ff <= rd_ptr_ff + 7'h01;
      end
      if (do_push && !do_pop) begin
        cnt_ff <= cnt_ff + 8'h01;
      end else if (do_pop && !do_push && !do_over) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
      // set wins over the clear by a read
      if (do_over) begin
        ovr_ff <= 1'b1;
      end else if (do_pop) begin
        ovr_ff <= 1'b0;
      end
    end
  end

  assign fill_count     = cnt_ff;
  assign head_data      = mem_ff[rd_ptr_ff];
  assign overwrite_seen = ovr_ff;
endmodule // bso_sample_queue
`default_nettype wire

// ==== src/bso_regs.sv ====
`include "bso_defines.svh"
`default_nettype none
// Operation
// - seven-bit threshold, bit seven zero, resets zero
// - signed reference word in two bytes
// - reference captured only when zeroing/update enabled
// - signed offset word, host programmable
// - boot bit high while trim reload runs
// - any-event flag when an interrupt occurred
// - bit one low event, bit zero high
// - fill count, zero empty, 128 full
// - threshold flag when fill at least a nonzero threshold
// - overwrite flag when full and overwritten
// - complete flag when full, none overwritten
// - temperature overrun on overwritten result
// - pressure overrun on overwritten result
// - temperature ready on new result
// - pressure ready on new result
// - status refreshed once per output period, and at once when a single shot completes; a temperature arriving with the shot sample waits for the next rate_tick
// - 24-bit pressure, low byte lowest address
// - pressure output equals measurement minus offset only with diff interrupt, zeroing and auto update off
// - 16-bit temperature, low byte first
// - queue low byte gives oldest sample
// - halt option caps queue at threshold
// - single shot self clears, updates results
module bso_regs
  import bso_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  input  wire bso_sample_t sample,
  input  wire logic        rate_tick,
  input  wire bso_ctrl_t   ctrl,
  input  wire bso_event_t  events,
  input  wire logic        single_shot_req,
  input  wire logic [15:0] ref_measured,
  output logic             single_shot_busy,
  output logic [15:0]      offset_word
);
  // ----------------------------------------------------------------
  // input synchronisers for pins from the analog side
  // ----------------------------------------------------------------
  bso_event_t  ev_meta_ff;
  bso_event_t  ev_sync_ff;

  // both stages reset low, so no false event follows reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ev_meta_ff <= '0;
    end else begin
      ev_meta_ff <= events;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ev_sync_ff <= '0;
    end else begin
      ev_sync_ff <= ev_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  logic [6:0]  threshold_level_ff;
  logic [15:0] offset_word_ff;
  logic [15:0] ref_word_ff;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      threshold_level_ff <= `BSO_RST_THRESHOLD;
    end else if (reg_wr && reg_addr == `BSO_ADR_THRESHOLD) begin
      // bit seven is never stored, so it always reads zero
      threshold_level_ff <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      offset_word_ff <= `BSO_RST_WORD;
    end else if (reg_wr && reg_addr == `BSO_ADR_OFS_LOW) begin
      offset_word_ff[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == `BSO_ADR_OFS_HIGH) begin
      offset_word_ff[15:8] <= reg_wdata;
    end
  end

  // software cannot write the reference; it is latched from a sample in the enable edge cycle, or on every sample under auto update
  logic ref_en_ff;
  logic ref_en;
  assign ref_en = ctrl.zero_capture || ctrl.ref_auto_update;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ref_en_ff <= 1'b0;
    end else begin
      ref_en_ff <= ref_en;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ref_word_ff <= `BSO_RST_WORD;
    end else if (ref_en && (!ref_en_ff || ctrl.ref_auto_update) && sample.press_valid) begin
      ref_word_ff <= ref_measured;
    end
  end

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  logic [23:0] press_result_ff;
  logic [15:0] temp_result_ff;
  logic [23:0] offset_ext;
  logic        plain_path;
  logic        shot_pending_ff;
  logic        shot_done;

  assign offset_ext = {{8{offset_word_ff[15]}}, offset_word_ff};
  assign plain_path = !ctrl.diff_interrupt_enable && !ctrl.zero_capture
                      && !ctrl.ref_auto_update;
  assign shot_done  = shot_pending_ff && sample.press_valid;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      press_result_ff <= 24'h000000;
    end else if (sample.press_valid) begin
      // result bytes change only on new samples, never on reads
      press_result_ff <= plain_path ? (sample.press_raw - offset_ext)
                                    : sample.press_raw;
    end
  end

  // temperature has no offset path; it is stored as measured
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      temp_result_ff <= 16'h0000;
    end else if (sample.temp_valid) begin
      temp_result_ff <= sample.temp_raw;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shot_pending_ff <= 1'b0;
    end else if (single_shot_req) begin
      shot_pending_ff <= 1'b1;
    end else if (shot_done) begin
      shot_pending_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  logic press_ready_ff;
  logic temp_ready_ff;
  logic press_ovr_ff;
  logic temp_ovr_ff;
  logic press_new_ff;
  logic temp_new_ff;
  logic press_read;
  logic temp_read;

  assign press_read = reg_rd && reg_addr == `BSO_ADR_PRESS_HIGH;
  assign temp_read  = reg_rd && reg_addr == `BSO_ADR_TEMP_HIGH;

  // sample events gather between ticks, then are published per period
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      press_new_ff <= 1'b0;
    end else begin
      // a shot sample is published at once; held again it would fake an overrun
      press_new_ff <= (sample.press_valid && !shot_done)
                      || (press_new_ff && !rate_tick && !shot_done);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      temp_new_ff <= 1'b0;
    end else begin
      temp_new_ff <= sample.temp_valid || (temp_new_ff && !rate_tick);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      press_ready_ff <= 1'b0;
      temp_ready_ff  <= 1'b0;
      press_ovr_ff   <= 1'b0;
      temp_ovr_ff    <= 1'b0;
    end else if (rate_tick || shot_done) begin
      // new data sets before a read clears
      if (press_new_ff || shot_done) begin
        press_ready_ff <= 1'b1;
        press_ovr_ff   <= press_ready_ff;
      end else if (press_read) begin
        press_ready_ff <= 1'b0;
        press_ovr_ff   <= 1'b0;
      end
      if (temp_new_ff) begin
        temp_ready_ff <= 1'b1;
        temp_ovr_ff   <= temp_ready_ff;
      end else if (temp_read) begin
        temp_ready_ff <= 1'b0;
        temp_ovr_ff   <= 1'b0;
      end
    end else begin
      if (press_read) begin
        press_ready_ff <= 1'b0;
        press_ovr_ff   <= 1'b0;
      end
      if (temp_read) begin
        temp_ready_ff <= 1'b0;
        temp_ovr_ff   <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sample queue
  // ----------------------------------------------------------------
  logic [7:0]  fill_count;
  logic [23:0] queue_head;
  logic        queue_overwrite;
  logic        queue_pop;

  // reading the queue low byte pops one entry
  assign queue_pop = reg_rd && reg_addr == `BSO_ADR_QUEUE_PLOW;

  bso_sample_queue u_queue (
    .sys_clk           (sys_clk),
    .rstn              (rstn),
    .push              (sample.press_valid),
    .push_data         (sample.press_raw),
    .pop               (queue_pop),
    .halt_at_threshold (ctrl.halt_at_threshold),
    .stream_mode       (ctrl.stream_mode),
    .threshold_level   (threshold_level_ff),
    .fill_count        (fill_count),
    .head_data         (queue_head),
    .overwrite_seen    (queue_overwrite)
  );

  logic       threshold_reached_flag;
  logic       queue_complete_flag;
  logic [7:0] q_limit;

  assign q_limit = ctrl.halt_at_threshold ? {1'b0, threshold_level_ff} : `BSO_QUEUE_FULL;
  // a zero threshold leaves the flag idle, so it reads zero after reset
  assign threshold_reached_flag = (threshold_level_ff != 7'h00)
                                  && (fill_count >= {1'b0, threshold_level_ff});
  assign queue_complete_flag    = (fill_count >= q_limit) && !queue_overwrite;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;

  always_comb begin
    nxt_rdata = `BSO_RST_BYTE;
    case (reg_addr)
      `BSO_ADR_THRESHOLD:   nxt_rdata = {1'b0, threshold_level_ff};
      `BSO_ADR_REF_LOW:     nxt_rdata = ref_word_ff[7:0];
      `BSO_ADR_REF_HIGH:    nxt_rdata = ref_word_ff[15:8];
      `BSO_ADR_OFS_LOW:     nxt_rdata = offset_word_ff[7:0];
      `BSO_ADR_OFS_HIGH:    nxt_rdata = offset_word_ff[15:8];
      `BSO_ADR_INT_ORIGIN: begin
        nxt_rdata[`BSO_BIT_BOOT_RUN]  = ev_sync_ff.boot_run;
        nxt_rdata[`BSO_BIT_ANY_EVENT] = ev_sync_ff.diff_low_event
                                        || ev_sync_ff.diff_high_event;
        nxt_rdata[`BSO_BIT_DIFF_LOW]  = ev_sync_ff.diff_low_event;
        nxt_rdata[`BSO_BIT_DIFF_HIGH] = ev_sync_ff.diff_high_event;
      end
      `BSO_ADR_FILL_LEVEL:  nxt_rdata = fill_count;
      `BSO_ADR_QUEUE_FLAGS: begin
        nxt_rdata[`BSO_BIT_THR_REACHED] = threshold_reached_flag;
        nxt_rdata[`BSO_BIT_OVERWRITE]   = queue_overwrite;
        nxt_rdata[`BSO_BIT_COMPLETE]    = queue_complete_flag;
      end
      `BSO_ADR_STATUS: begin
        nxt_rdata[`BSO_BIT_TEMP_OVR]    = temp_ovr_ff;
        nxt_rdata[`BSO_BIT_PRESS_OVR]   = press_ovr_ff;
        nxt_rdata[`BSO_BIT_TEMP_READY]  = temp_ready_ff;
        nxt_rdata[`BSO_BIT_PRESS_READY] = press_ready_ff;
      end
      `BSO_ADR_PRESS_LOW:   nxt_rdata = press_result_ff[7:0];
      `BSO_ADR_PRESS_MID:   nxt_rdata = press_result_ff[15:8];
      `BSO_ADR_PRESS_HIGH:  nxt_rdata = press_result_ff[23:16];
      `BSO_ADR_TEMP_LOW:    nxt_rdata = temp_result_ff[7:0];
      `BSO_ADR_TEMP_HIGH:   nxt_rdata = temp_result_ff[15:8];
      `BSO_ADR_QUEUE_PLOW:  nxt_rdata = queue_head[7:0];
      default:              nxt_rdata = `BSO_RST_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= `BSO_RST_BYTE;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic [15:0] offset_out_ff;
  logic        busy_out_ff;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      offset_out_ff <= `BSO_RST_WORD;
    end else begin
      offset_out_ff <= offset_word_ff;
    end
  end

  // busy trails pending by a cycle and drops when the shot completes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy_out_ff <= 1'b0;
    end else begin
      busy_out_ff <= shot_pending_ff && !shot_done;
    end
  end

  assign reg_rdata        = rdata_ff;
  assign offset_word      = offset_out_ff;
  assign single_shot_busy = busy_out_ff;
endmodule // bso_regs
`default_nettype wire

// ==== bench/bso_regs_sva.sv ====
`default_nettype none
module bso_regs_sva
  import bso_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire bso_sample_t sample,
  input wire logic        single_shot_req,
  input wire logic        single_shot_busy,
  input wire logic [15:0] offset_word
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // write sequences, quiet cycles keep a later write from masking
  // ----------------------------------------------------------------
  sequence s_thr_wr;
    reg_wr && reg_addr == 8'h14 ##1 !reg_wr ##1 reg_rd && reg_addr == 8'h14;
  endsequence
  sequence s_lo_wr;
    reg_wr && reg_addr == 8'h18 ##1 (!(reg_wr && reg_addr == 8'h18)) [*2];
  endsequence
  sequence s_hi_wr;
    reg_wr && reg_addr == 8'h19 ##1 (!(reg_wr && reg_addr == 8'h19)) [*2];
  endsequence
  property p_thr_rw;
    s_thr_wr |=> reg_rdata == {1'h0, $past(reg_wdata[6:0], 3)};
  endproperty
  a_thr_rw: assert property (p_thr_rw)
    else $error("threshold readback wrong");
  property p_thr_top;
    reg_rd && reg_addr == 8'h14 |=> !reg_rdata[7];
  endproperty
  a_thr_top: assert property (p_thr_top)
    else $error("threshold top bit set");
  property p_ofs_lo;
    s_lo_wr |=> offset_word[7:0] == $past(reg_wdata, 3);
  endproperty
  a_ofs_lo: assert property (p_ofs_lo)
    else $error("offset low byte not applied");
  property p_ofs_hi;
    s_hi_wr |=> offset_word[15:8] == $past(reg_wdata, 3);
  endproperty
  a_ofs_hi: assert property (p_ofs_hi)
    else $error("offset high byte not applied");
  property p_any;
    reg_rd && reg_addr == 8'h24 |=> reg_rdata[2] == (|reg_rdata[1:0]);
  endproperty
  a_any: assert property (p_any)
    else $error("any-event flag mismatch");
  property p_src_rsv;
    reg_rd && reg_addr == 8'h24 |=> reg_rdata[6:3] == 4'h0;
  endproperty
  a_src_rsv: assert property (p_src_rsv)
    else $error("event source unused bits set");
  property p_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved without a read");
  // busy is registered behind pending, so it shows two edges after the request
  sequence s_shot_wait;
    single_shot_req ##1 !sample.press_valid;
  endsequence
  property p_shot_set;
    s_shot_wait |=> single_shot_busy;
  endproperty
  a_shot_set: assert property (p_shot_set)
    else $error("single shot not started");
  property p_shot_done;
    single_shot_busy && sample.press_valid && !single_shot_req |=> !single_shot_busy;
  endproperty
  a_shot_done: assert property (p_shot_done)
    else $error("single shot did not self clear");
endmodule // bso_regs_sva

bind bso_regs bso_regs_sva i_sva (
  .sys_clk(sys_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample(sample),
  .single_shot_req(single_shot_req), .single_shot_busy(single_shot_busy),
  .offset_word(offset_word)
);
`default_nettype wire

// ==== bench/bso_host_model.sv ====
`default_nettype none
module bso_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // ----------------------------------------------------------------
  // bus cycles: released lines show inverted values, not stale ones
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // data is registered, so it is taken two edges after the request
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    reg_addr <= ~a;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
endmodule // bso_host_model
`default_nettype wire

// ==== bench/test_baro_status_output_regs.sv ====
`default_nettype none
module test_baro_status_output_regs import bso_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic       w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } bso_row_t;
  logic        sys_clk;
  logic        rstn;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  bso_sample_t sample;
  logic        rate_tick;
  bso_ctrl_t   ctrl;
  bso_event_t  events;
  logic        single_shot_req;
  logic [15:0] ref_measured;
  logic [15:0] offset_word;
  logic        single_shot_busy;
  int          err_count;
  int          tests_run;
  int          cyc;
  bso_event_t  ev_tab [3] = '{3'h4, 3'h2, 3'h1};
  logic [7:0]  ev_exp [3] = '{8'h80, 8'h06, 8'h05};
  bso_row_t    rows [14] = '{
    '{1'h0, 8'h14, 8'h00, 8'h00},
    '{1'h0, 8'h15, 8'h00, 8'h00},
    '{1'h0, 8'h16, 8'h00, 8'h00},
    '{1'h0, 8'h18, 8'h00, 8'h00},
    '{1'h0, 8'h24, 8'h00, 8'h00},
    '{1'h0, 8'h25, 8'h00, 8'h00},
    '{1'h0, 8'h26, 8'h00, 8'h00},
    '{1'h1, 8'h14, 8'hFF, 8'h00},
    '{1'h0, 8'h14, 8'h00, 8'h7F},
    '{1'h1, 8'h18, 8'h10, 8'h00},
    '{1'h1, 8'h19, 8'h00, 8'h00},
    '{1'h0, 8'h18, 8'h00, 8'h10},
    '{1'h1, 8'h15, 8'hAA, 8'h00},
    '{1'h0, 8'h15, 8'h00, 8'h00}};
  bso_regs i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample(sample), .rate_tick(rate_tick),
    .ctrl(ctrl), .events(events), .single_shot_req(single_shot_req),
    .ref_measured(ref_measured), .single_shot_busy(single_shot_busy),
    .offset_word(offset_word));
  bso_host_model i_host (
    .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_host.rd(a, v);
    tests_run++;
    if (v !== e) begin
      err_count++;
      $display("unexpected %0t addr %h got %h want %h", $time, a, v, e);
    end
  endtask
  task automatic cmp16(input logic [15:0] v, input logic [15:0] e);
    tests_run++;
    if (v !== e) begin
      err_count++;
      $display("unexpected %0t word got %h want %h", $time, v, e);
    end
  endtask
  task automatic smp(input logic pv, input logic [23:0] p, input logic tv,
                     input logic [15:0] t, input logic tk);
    @(posedge sys_clk);
    sample <= '{pv, p, tv, t};
    @(posedge sys_clk);
    sample <= '0;
    rate_tick <= tk;
    @(posedge sys_clk);
    rate_tick <= 1'h0;
  endtask
  task automatic print_verdict();
    $display("mismatches %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ceiling well above the roughly 580 cycles the sequence needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    rstn = 1'h0;
    sample = '0;
    rate_tick = 1'h0;
    ctrl = '0;
    events = '0;
    single_shot_req = 1'h0;
    ref_measured = 16'h5A5A;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        i_host.wr(rows[i].a, rows[i].d);
      end else begin
        chk(rows[i].a, rows[i].e);
      end
    end
    cmp16(offset_word, 16'h0010);
    smp(1'h1, 24'h123456, 1'h0, 16'h0000, 1'h1);
    chk(8'h27, 8'h01);
    chk(8'h28, 8'h46);
    chk(8'h29, 8'h34);
    chk(8'h2A, 8'h12);
    chk(8'h28, 8'h46);
    chk(8'h15, 8'h00);
    smp(1'h1, 24'h000001, 1'h1, 16'h8001, 1'h1);
    smp(1'h1, 24'h000002, 1'h1, 16'h8002, 1'h1);
    chk(8'h27, 8'h33);
    chk(8'h2B, 8'h02);
    chk(8'h2C, 8'h80);
    chk(8'h2A, 8'hFF);
    chk(8'h27, 8'h00);
    @(posedge sys_clk);
    single_shot_req <= 1'h1;
    @(posedge sys_clk);
    single_shot_req <= 1'h0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    cmp16({15'h0000, single_shot_busy}, 16'h0001);
    smp(1'h1, 24'h000020, 1'h0, 16'h0000, 1'h0);
    cmp16({15'h0000, single_shot_busy}, 16'h0000);
    chk(8'h27, 8'h01);
    chk(8'h28, 8'h10);
    for (int i = 0; i < 3; i++) begin
      events <= ev_tab[i];
      repeat (4) @(posedge sys_clk);
      chk(8'h24, ev_exp[i]);
    end
    events <= '0;
    ref_measured <= 16'hABCD;
    ctrl.ref_auto_update <= 1'h1;
    smp(1'h1, 24'h000000, 1'h0, 16'h0000, 1'h1);
    chk(8'h15, 8'hCD);
    chk(8'h16, 8'hAB);
    ctrl <= '0;
    rstn <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'h1;
    chk(8'h18, 8'h00);
    chk(8'h14, 8'h00);
    cmp16(offset_word, 16'h0000);
    i_host.wr(8'h14, 8'h02);
    ctrl.stream_mode <= 1'h1;
    smp(1'h1, 24'h0000A1, 1'h0, 16'h0000, 1'h0);
    smp(1'h1, 24'h0000A2, 1'h0, 16'h0000, 1'h0);
    chk(8'h25, 8'h02);
    chk(8'h26, 8'h80);
    chk(8'h78, 8'hA1);
    chk(8'h25, 8'h01);
    chk(8'h26, 8'h00);
    ctrl.halt_at_threshold <= 1'h1;
    smp(1'h1, 24'h0000A3, 1'h0, 16'h0000, 1'h0);
    smp(1'h1, 24'h0000A4, 1'h0, 16'h0000, 1'h0);
    chk(8'h25, 8'h02);
    chk(8'h26, 8'hA0);
    ctrl.halt_at_threshold <= 1'h0;
    for (int i = 0; i < 126; i++) begin
      smp(1'h1, 24'h000100, 1'h0, 16'h0000, 1'h0);
    end
    chk(8'h25, 8'h80);
    chk(8'h26, 8'hA0);
    smp(1'h1, 24'h000101, 1'h0, 16'h0000, 1'h0);
    chk(8'h26, 8'hC0);
    chk(8'h25, 8'h80);
    print_verdict();
  end
endmodule // test_baro_status_output_regs
`default_nettype wire
